// *** combo_bus_pkg.sv ***
// package for the combo memory bus controller: register map, pin groups
// assumes a single 20 MHz clock domain and an AHB-Lite software port
package combo_bus_pkg;
  localparam logic [7:0] off_ctrl = 8'h00;
  localparam logic [7:0] off_addr = 8'h04;
  localparam logic [7:0] off_wdata = 8'h08;
  localparam logic [7:0] off_status = 8'h0c;
  localparam logic [7:0] off_pins = 8'h10;
  localparam logic [7:0] off_cycles = 8'h14;
  // ctrl fields
  localparam int ctrl_go = 0;
  localparam int ctrl_write = 1;
  localparam int ctrl_ram = 2;
  localparam int ctrl_sleep = 3;
  localparam int ctrl_flash_rst = 4;
  localparam int ctrl_wait_high = 5;
  localparam int ctrl_ub = 6;
  localparam int ctrl_lb = 7;
  localparam logic [7:0] ctrl_reset = 8'h00;
  localparam int addr_w = 22;
  localparam int data_w = 16;
  localparam int cyc_w = 8;
  localparam logic [cyc_w-1:0] cycles_reset = 8'h04;
  // flash wait polarity bit in the flash read config register
  localparam int flash_wait_pol_bit = 10;
  // query offset reporting ram density
  localparam logic [addr_w-1:0] query_ram_density = 22'h000078;
  localparam logic [data_w-1:0] ram_density_16m = 16'h0010;
  localparam logic [data_w-1:0] ram_density_32m = 16'h0020;
  localparam logic [data_w-1:0] ram_density_64m = 16'h0040;
  localparam int ram_deep_power_bit = 4;
  localparam logic [1:0] htrans_nonseq = 2'b10;

  typedef struct packed {
    logic flash_chip_sel_n;
    logic flash_out_en_n;
    logic flash_write_en_n;
    logic flash_reset_n;
    logic flash_address_valid_n;
    logic ram_chip_sel_n;
    logic ram_sleep_n;
    logic ram_out_en_n;
    logic ram_write_en_n;
    logic ram_upper_byte_n;
    logic ram_lower_byte_n;
  } mem_ctl_t;

  typedef enum logic [3:0] {
    st_idle = 4'b0001,
    st_setup = 4'b0010,
    st_strobe = 4'b0100,
    st_release = 4'b1000
  } cyc_state_t;
endpackage

// *** combo_bus_ctrl.sv ***
// controller for a stacked flash + pseudo-static ram on one shared bus
// assumes async/page use only; ahb-lite slave with a single master
//
// The address map and the AHB-Lite slave port are this design's own decisions.
`timescale 1ns/1ns
// What this block does
// - flash write: chip, we low; we drive bus
// - keep ram off bus during flash access
// - ram write: chip, we, bytes low; we drive
// - keep flash off bus during ram access
// - wait pin never acted on; only shown in status
// - address valid unused; held low
module combo_bus_ctrl (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  output logic [combo_bus_pkg::addr_w-1:0] mem_addr,
  output combo_bus_pkg::mem_ctl_t mem_ctl,
  output logic [combo_bus_pkg::data_w-1:0] mem_dq_out,
  output logic mem_dq_oe,
  input wire logic [combo_bus_pkg::data_w-1:0] mem_dq_in,
  input wire logic flash_wait_n
);
  import combo_bus_pkg::*;

  logic [7:0] ctrl;
  logic [addr_w-1:0] addr;
  logic [data_w-1:0] wdata;
  logic [data_w-1:0] rdata;
  logic [cyc_w-1:0] cycles;
  logic [cyc_w-1:0] count;
  logic busy;
  logic [7:0] ph_addr;
  logic ph_write;
  logic ph_valid;
  cyc_state_t state;
  // wait pin is synchronised only so it can be shown; never acted on
  logic [2:0] wait_sync;
  logic wait_seen;

  wire take = hsel && hready && htrans == htrans_nonseq;
  wire wr_hit = ph_valid && ph_write;
  wire go = wr_hit && ph_addr == off_ctrl && hwdata[ctrl_go] && !busy;
  wire op_write = ctrl[ctrl_write];
  wire op_ram = ctrl[ctrl_ram];
  wire strobe = state == st_strobe;
  wire active = state != st_idle;
  wire count_done = count == '0;
  wire flash_rst_n = ctrl[ctrl_flash_rst];

  function automatic logic [31:0] read_mux(input logic [7:0] a);
    case (a)
      off_ctrl: read_mux = {24'h000000, ctrl};
      off_addr: read_mux = {10'h000, addr};
      off_wdata: read_mux = {16'h0000, wdata};
      off_status: read_mux = {14'h0000, wait_seen, busy, rdata};
      off_pins: read_mux = {21'h000000, mem_ctl};
      off_cycles: read_mux = {24'h000000, cycles};
      default: read_mux = 32'h00000000;
    endcase
  endfunction

  // bus slave: zero wait states, always OKAY
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      ph_valid <= 1'b0;
      ph_write <= 1'b0;
      ph_addr <= 8'h00;
      hrdata <= 32'h00000000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      ph_valid <= take;
      ph_write <= hwrite;
      ph_addr <= haddr[7:0];
      if (take && !hwrite) begin
        hrdata <= read_mux(haddr[7:0]);
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      ctrl <= ctrl_reset;
      addr <= '0;
      wdata <= '0;
      cycles <= cycles_reset;
    end else if (wr_hit) begin
      if (ph_addr == off_ctrl) begin
        ctrl <= {hwdata[7:1], 1'b0};
      end
      if (ph_addr == off_addr) begin
        addr <= hwdata[addr_w-1:0];
      end
      if (ph_addr == off_wdata) begin
        wdata <= hwdata[data_w-1:0];
      end
      if (ph_addr == off_cycles) begin
        cycles <= hwdata[cyc_w-1:0];
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      wait_sync <= 3'b111;
      wait_seen <= 1'b0;
    end else begin
      wait_sync <= {wait_sync[1:0], flash_wait_n};
      if (wait_sync[2] == wait_sync[1]) begin
        // polarity follows ctrl_wait_high in the ctrl register; info only
        wait_seen <= wait_sync[2] ^ !ctrl[ctrl_wait_high];
      end
    end
  end

  // cycle sequencer: setup, strobe for cycles+1, release
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      state <= st_idle;
      count <= '0;
      busy <= 1'b0;
      rdata <= '0;
    end else begin
      case (state)
        st_idle: begin
          if (go) begin
            state <= st_setup;
            busy <= 1'b1;
          end
        end
        st_setup: begin
          state <= st_strobe;
          count <= cycles;
        end
        st_strobe: begin
          if (count_done) begin
            state <= st_release;
            if (!op_write) begin
              rdata <= mem_dq_in;
            end
          end else begin
            count <= count - 1'b1;
          end
        end
        st_release: begin
          state <= st_idle;
          busy <= 1'b0;
        end
        default: state <= st_idle;
      endcase
    end
  end

  // the idle die is always fully deselected so it floats the bus
  wire flash_sel = active && !op_ram && flash_rst_n;
  wire ram_sel = active && op_ram;
  mem_ctl_t next_ctl;
  always_comb begin
    next_ctl.flash_chip_sel_n = !flash_sel;
    next_ctl.flash_out_en_n = !(flash_sel && strobe && !op_write);
    next_ctl.flash_write_en_n = !(flash_sel && strobe && op_write);
    next_ctl.flash_reset_n = flash_rst_n;
    next_ctl.flash_address_valid_n = 1'b0;
    next_ctl.ram_chip_sel_n = !ram_sel;
    // sleep low with chip deselected: deep sleep or config access
    // forced high while the ram is selected, so no access runs asleep
    next_ctl.ram_sleep_n = !(ctrl[ctrl_sleep] && !ram_sel);
    next_ctl.ram_out_en_n = !(ram_sel && strobe && !op_write);
    next_ctl.ram_write_en_n = !(ram_sel && strobe && op_write);
    next_ctl.ram_upper_byte_n = !(ram_sel && ctrl[ctrl_ub]);
    next_ctl.ram_lower_byte_n = !(ram_sel && ctrl[ctrl_lb]);
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      mem_ctl <= '{1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1,
                   1'b1, 1'b1};
      mem_addr <= '0;
      mem_dq_out <= '0;
      mem_dq_oe <= 1'b0;
    end else begin
      mem_ctl <= next_ctl;
      mem_addr <= addr;
      mem_dq_out <= wdata;
      // drive for the whole write access: setup, strobe and release
      mem_dq_oe <= active && op_write && (op_ram || flash_rst_n);
    end
  end

  property p_one_die;
    @(posedge clk_sys) disable iff (!rst_b)
      !(!mem_ctl.flash_chip_sel_n && !mem_ctl.ram_chip_sel_n);
  endproperty
  a_one_die: assert property (p_one_die)
    else $error("both dies selected");

  property p_ram_read;
    @(posedge clk_sys) disable iff (!rst_b)
      !mem_ctl.ram_out_en_n |-> !mem_ctl.ram_chip_sel_n &&
        mem_ctl.ram_write_en_n && !mem_dq_oe;
  endproperty
  a_ram_read: assert property (p_ram_read)
    else $error("bad ram read");

  property p_flash_read;
    @(posedge clk_sys) disable iff (!rst_b)
      !mem_ctl.flash_out_en_n |-> !mem_ctl.flash_chip_sel_n &&
        mem_ctl.flash_write_en_n && mem_ctl.flash_reset_n;
  endproperty
  a_flash_read: assert property (p_flash_read)
    else $error("bad flash read");

  property p_flash_write;
    @(posedge clk_sys) disable iff (!rst_b)
      !mem_ctl.flash_write_en_n |-> mem_dq_oe && mem_ctl.flash_out_en_n;
  endproperty
  a_flash_write: assert property (p_flash_write)
    else $error("flash wr");

  property p_ram_write;
    @(posedge clk_sys) disable iff (!rst_b)
      !mem_ctl.ram_write_en_n |-> mem_dq_oe && mem_ctl.ram_sleep_n;
  endproperty
  a_ram_write: assert property (p_ram_write) else $error("ram wr");

  sequence s_start;
    go;
  endsequence
  sequence s_strobe_on;
    ##2 strobe;
  endsequence
  property p_seq;
    @(posedge clk_sys) disable iff (!rst_b) s_start |-> s_strobe_on;
  endproperty
  a_seq: assert property (p_seq)
    else $error("no strobe after go");

  property p_rst_idle;
    @(posedge clk_sys) disable iff (!rst_b)
      !mem_ctl.flash_reset_n |-> mem_ctl.flash_write_en_n &&
        mem_ctl.flash_out_en_n;
  endproperty
  a_rst_idle: assert property (p_rst_idle)
    else $error("strobe in reset");

  property p_adv;
    @(posedge clk_sys) disable iff (!rst_b)
      $past(rst_b) |-> !mem_ctl.flash_address_valid_n;
  endproperty
  a_adv: assert property (p_adv) else $error("adv toggled");
endmodule

// *** combo_mem_model.sv ***
// behavioural stacked flash + ram sharing one bus, for the bench
// assumes async/page use; a write lands on the rising write enable
`timescale 1ns/1ns
module combo_mem_model #(
  parameter logic [15:0] density = 16'h0040,
  parameter bit top_boot = 1'b0
) (
  input wire logic [21:0] mem_addr,
  input combo_bus_pkg::mem_ctl_t mem_ctl,
  input wire logic [15:0] dq_out,
  input wire logic dq_oe,
  output logic [15:0] dq_in,
  output logic wait_n,
  output logic clash
);
  import combo_bus_pkg::*;
  logic [15:0] fl [int];
  logic [15:0] rm [int];
  logic [15:0] last = 16'h0000;
  logic deep_bit = 1'b0;
  logic wait_hi = 1'b0;
  wire f_on = !mem_ctl.flash_chip_sel_n
    && mem_ctl.flash_reset_n;
  wire f_rd = f_on && !mem_ctl.flash_out_en_n
    && mem_ctl.flash_write_en_n;
  wire r_on = !mem_ctl.ram_chip_sel_n && mem_ctl.ram_sleep_n
    && !mem_ctl.ram_upper_byte_n && !mem_ctl.ram_lower_byte_n;
  wire r_rd = r_on && !mem_ctl.ram_out_en_n
    && mem_ctl.ram_write_en_n;
  function automatic logic [15:0] rd_die(input bit ram, input int a);
    if (!ram && a == 'h78) return density;
    // id codes arbitrary, differ only by boot configuration
    if (!ram && a == 0) return top_boot ? 16'h00a1 : 16'h00a2;
    if (ram) return rm.exists(a) ? rm[a] : a[15:0] ^ 16'h5a5a;
    return fl.exists(a) ? fl[a] : a[15:0] ^ 16'h5a5a;
  endfunction
  // released bus shows the inverse of the last level, no pull on it
  always @(dq_oe, dq_out, f_rd, r_rd, mem_addr) begin
    if (dq_oe) dq_in = dq_out;
    else if (f_rd || r_rd) dq_in = rd_die(r_rd, mem_addr);
    else dq_in = ~last;
    last = dq_in;
  end
  always @(posedge mem_ctl.flash_write_en_n)
    if (f_on && mem_ctl.flash_out_en_n) fl[mem_addr] = dq_out;
  always @(posedge mem_ctl.ram_write_en_n)
    if (r_on && mem_ctl.ram_out_en_n) rm[mem_addr] = dq_out;
  // deep sleep drops refresh, so contents are lost
  always @(negedge mem_ctl.ram_sleep_n)
    if (!deep_bit) rm.delete();
  assign clash = (f_rd && r_rd) || (dq_oe && (f_rd || r_rd));
  assign wait_n = f_on ? !wait_hi : wait_hi;
endmodule

// *** combo_bus_ctrl_tb.sv ***
// self-checking bench for combo_bus_ctrl with a behavioural memory
// assumes combo_mem_model on the far side and a 20 MHz clock
`timescale 1ns/1ns
module combo_bus_ctrl_tb;
  import combo_bus_pkg::*;
  logic clk_sys = 1'b0, rst_b = 1'b0, hwrite = 1'b0, hreadyout, hresp;
  // both byte lanes enabled, or no ram access takes effect
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd, ctl = 32'hc0;
  logic [1:0] htrans = 2'h0;
  logic mem_dq_oe, flash_wait_n, clash, clash_seen = 1'b0;
  logic [addr_w-1:0] mem_addr, a;
  logic [addr_w-1:0] pool [4];
  mem_ctl_t mem_ctl;
  logic [data_w-1:0] mem_dq_out, mem_dq_in, q, e;
  logic [15:0] fl_ref [int];
  logic [15:0] rm_ref [int];
  bit r, w;
  int miscompares = 0, n_checks = 0;
  initial forever #25 clk_sys = ~clk_sys;
  combo_bus_ctrl combo_bus_ctrl_inst (.clk_sys(clk_sys), .rst_b(rst_b),
    .hsel(1'b1), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .mem_addr(mem_addr),
    .mem_ctl(mem_ctl), .mem_dq_out(mem_dq_out), .mem_dq_oe(mem_dq_oe),
    .mem_dq_in(mem_dq_in), .flash_wait_n(flash_wait_n));
  combo_mem_model combo_mem_model_inst (.mem_addr(mem_addr),
    .mem_ctl(mem_ctl), .dq_out(mem_dq_out), .dq_oe(mem_dq_oe),
    .dq_in(mem_dq_in), .wait_n(flash_wait_n), .clash(clash));
  always @(posedge clk_sys) if (clash === 1'b1) clash_seen <= 1'b1;
  task automatic results();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic hwait();
    int n;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (hreadyout !== 1'b1 && n < 64);
    if (n >= 64) begin
      miscompares++;
      results();
    end
  endtask
  task automatic ahb(input bit wr, input logic [7:0] ad, input logic [31:0] wd);
    @(posedge clk_sys);
    htrans <= htrans_nonseq;
    haddr <= {24'h0, ad};
    hwrite <= wr;
    hwait();
    htrans <= 2'h0;
    hwdata <= wd;
    hwait();
    rd = hrdata;
  endtask
  task automatic mem_op(input bit ram, input bit wr);
    int n;
    ahb(1, off_addr, {10'h0, a});
    ahb(1, off_wdata, {16'h0, e});
    ahb(1, off_ctrl, ctl | 32'h1 | (wr << 1) | (ram << 2));
    n = 0;
    do begin
      ahb(0, off_status, 32'h0);
      n++;
    end while (rd[16] !== 1'b0 && n < 64);
    if (n >= 64) begin
      miscompares++;
      results();
    end
    q = rd[15:0];
  endtask
  function automatic logic [15:0] exp_rd(bit ram, int ad);
    if (!ram && ad == 'h78) return ram_density_64m;
    if (ram) return rm_ref.exists(ad) ? rm_ref[ad] : ad[15:0] ^ 16'h5a5a;
    return fl_ref.exists(ad) ? fl_ref[ad] : ad[15:0] ^ 16'h5a5a;
  endfunction
  initial begin
    void'($urandom(28562));
    foreach (pool[i]) pool[i] = $urandom;
    repeat (4) @(posedge clk_sys);
    chk(mem_ctl.flash_reset_n, 32'h0);
    chk({mem_ctl.flash_chip_sel_n, mem_ctl.ram_chip_sel_n}, 32'h3);
    chk(mem_dq_oe, 32'h0);
    rst_b <= 1'b1;
    ahb(0, off_cycles, 32'h0);
    chk(rd, {24'h0, cycles_reset});
    ahb(0, 8'h40, 32'h0);
    chk(rd, 32'h0);
    ahb(0, off_pins, 32'h0);
    chk(rd, 32'h0000073f);
    chk(hresp, 32'h0);
    $display("test reset done");
    // ram use while the flash is still held in reset
    a = pool[0];
    e = 16'hc3a5;
    mem_op(1, 1);
    rm_ref[a] = e;
    mem_op(1, 0);
    chk(q, 16'hc3a5);
    ctl = 32'hd0;
    for (int i = 0; i < 24; i++) begin
      r = $urandom % 2;
      w = $urandom % 2;
      a = pool[$urandom % 4] | (r ? 22'h0 : 22'h100);
      e = $urandom;
      mem_op(r, w);
      if (w && r) rm_ref[a] = e;
      else if (w) fl_ref[a] = e;
      else chk(q, exp_rd(r, a));
    end
    a = 22'h78;
    mem_op(0, 0);
    chk(q, ram_density_64m);
    $display("test traffic done");
    ahb(1, off_ctrl, ctl | 32'h8);
    repeat (3) @(posedge clk_sys);
    chk(mem_ctl.ram_sleep_n, 32'h0);
    rm_ref.delete();
    ahb(1, off_ctrl, ctl);
    a = pool[0];
    mem_op(1, 0);
    chk(q, exp_rd(1, a));
    $display("test sleep done");
    // deselected flash leaves the wait pin low in the model
    chk(rd[17], 32'h1);
    ahb(1, off_ctrl, ctl | 32'h20);
    ahb(0, off_status, 32'h0);
    chk(rd[17], 32'h0);
    $display("test wait polarity done");
    chk(clash_seen, 32'h0);
    $display("test bus sharing done");
    results();
  end
endmodule
